// ### hdl/timer2_pkg.sv
// Package for the sixteen-bit capture/reload timer.
// Assumes a byte-wide special-function register bus with 8-bit addresses.
package timer2_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_CTRL     = 8'hC8;
	localparam logic [7:0] ADDR_HOLD_LO  = 8'hCA;
	localparam logic [7:0] ADDR_HOLD_HI  = 8'hCB;
	localparam logic [7:0] ADDR_COUNT_LO = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HI = 8'hCD;

	// ==========================================================
	// Reset values and widths
	localparam int         COUNT_W       = 16;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] BYTE_RESET    = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// ==========================================================
	// Control register layout, bit 7 first
	typedef struct packed {
		logic overflow_flag;
		logic ext_flag;
		logic rx_baud_sel;
		logic tx_baud_sel;
		logic ext_trigger_enable;
		logic timer_run_bit;
		logic counter_select;
		logic capture_reload_select;
	} timer_two_control_s;

	// One bus access as seen by the block
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_s;

endpackage : timer2_pkg

// ### hdl/timer2_capture_reload.sv
// Sixteen-bit timer with capture/reload from an external falling edge.
// Assumes the core drives one access per cycle on the register port and
// that the trigger pin is already synchronous to i_sys_clk.
module timer2_capture_reload (
	// Clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_arst_n,
	// Register port
	input  wire timer2_pkg::sfr_req_s  i_sfr,
	output logic [7:0]                 o_sfr_rdata,
	// Pins and flags
	input  wire logic                  i_ext_trigger_pin,
	output logic                       o_overflow_flag,
	output logic                       o_ext_flag
);

	// ==========================================================
	// State
	timer2_pkg::timer_two_control_s ctrl_q, ctrl_d;
	logic [timer2_pkg::COUNT_W-1:0] count_q, count_d;
	logic [timer2_pkg::COUNT_W-1:0] hold_q, hold_d;
	logic                           trig_prev_q;
	logic [7:0]                     rdata_q;

	// ==========================================================
	// Functions
	// Bytes of the count and holding pairs are written one at a time
	function automatic logic [timer2_pkg::COUNT_W-1:0] merge_bytes(
		input logic [timer2_pkg::COUNT_W-1:0] word,
		input logic [7:0]                     data,
		input logic                           lo_en,
		input logic                           hi_en
	);
		logic [timer2_pkg::COUNT_W-1:0] res;
		res = word;
		if (lo_en)
			res[7:0] = data;
		if (hi_en)
			res[15:8] = data;
		return res;
	endfunction : merge_bytes

	function automatic logic [7:0] pick_byte(
		input logic [timer2_pkg::COUNT_W-1:0] word,
		input logic                           hi
	);
		return hi ? word[15:8] : word[7:0];
	endfunction : pick_byte

	// ==========================================================
	// Decode
	wire sel_ctrl    = (i_sfr.addr == timer2_pkg::ADDR_CTRL);
	wire sel_hold_lo = (i_sfr.addr == timer2_pkg::ADDR_HOLD_LO);
	wire sel_hold_hi = (i_sfr.addr == timer2_pkg::ADDR_HOLD_HI);
	wire sel_cnt_lo  = (i_sfr.addr == timer2_pkg::ADDR_COUNT_LO);
	wire sel_cnt_hi  = (i_sfr.addr == timer2_pkg::ADDR_COUNT_HI);

	wire wr_ctrl    = i_sfr.wr && sel_ctrl;
	wire wr_hold_lo = i_sfr.wr && sel_hold_lo;
	wire wr_hold_hi = i_sfr.wr && sel_hold_hi;
	wire wr_cnt_lo  = i_sfr.wr && sel_cnt_lo;
	wire wr_cnt_hi  = i_sfr.wr && sel_cnt_hi;
	wire wr_count   = wr_cnt_lo || wr_cnt_hi;

	wire trig_fall  = trig_prev_q && !i_ext_trigger_pin;
	wire trig_evt   = ctrl_q.ext_trigger_enable && trig_fall;
	wire cap_evt    = trig_evt && ctrl_q.capture_reload_select;
	wire rld_trig   = trig_evt && !ctrl_q.capture_reload_select;
	wire running    = ctrl_q.timer_run_bit;
	wire at_max     = &count_q;
	wire rollover   = running && at_max;
	// Baud selections make rollover reload even with capture selected; edges still capture
	wire baud_mode  = ctrl_q.rx_baud_sel || ctrl_q.tx_baud_sel;
	wire auto_rld   = !ctrl_q.capture_reload_select || baud_mode;
	wire rld_ovf    = rollover && auto_rld;
	wire ovf_set    = rollover && !baud_mode;
	wire do_reload  = rld_trig || rld_ovf;
	wire [timer2_pkg::COUNT_W-1:0] count_inc = count_q + 16'h0001;

	// ==========================================================
	// Next values
	always_comb begin
		count_d = count_q;
		// Software write wins over reload and increment
		if (wr_count) begin
			count_d = merge_bytes(count_q, i_sfr.wdata, wr_cnt_lo, wr_cnt_hi);
		end else if (do_reload) begin
			count_d = hold_q;
		end else if (running) begin
			count_d = count_inc;
		end
	end

	always_comb begin
		hold_d = hold_q;
		// Capture wins over a software write to the holding bytes
		if (cap_evt) begin
			hold_d = count_q;
		end else begin
			hold_d = merge_bytes(hold_q, i_sfr.wdata, wr_hold_lo, wr_hold_hi);
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = timer2_pkg::timer_two_control_s'(i_sfr.wdata);
		if (ovf_set)
			ctrl_d.overflow_flag = 1'b1;
		if (trig_evt)
			ctrl_d.ext_flag = 1'b1;
	end

	wire [7:0] rd_mux =
		sel_ctrl    ? ctrl_q                   :
		sel_hold_lo ? pick_byte(hold_q, 1'b0)  :
		sel_hold_hi ? pick_byte(hold_q, 1'b1)  :
		sel_cnt_lo  ? pick_byte(count_q, 1'b0) :
		sel_cnt_hi  ? pick_byte(count_q, 1'b1) :
		timer2_pkg::READ_UNMAPPED;
	wire [7:0] rdata_d = i_sfr.rd ? rd_mux : rdata_q;

	// ==========================================================
	// Registers
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_q      <= timer2_pkg::CTRL_RESET;
			count_q     <= {timer2_pkg::BYTE_RESET, timer2_pkg::BYTE_RESET};
			hold_q      <= {timer2_pkg::BYTE_RESET, timer2_pkg::BYTE_RESET};
			// Preset high, so a pin held low through reset gives a falling edge in the first cycle after reset
			trig_prev_q <= 1'b1;
			rdata_q     <= timer2_pkg::READ_UNMAPPED;
		end else begin
			ctrl_q      <= ctrl_d;
			count_q     <= count_d;
			hold_q      <= hold_d;
			trig_prev_q <= i_ext_trigger_pin;
			rdata_q     <= rdata_d;
		end
	end

	assign o_sfr_rdata     = rdata_q;
	assign o_overflow_flag = ctrl_q.overflow_flag;
	assign o_ext_flag      = ctrl_q.ext_flag;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	a_halt_holds_count: assert property (
		!running && !wr_count && !do_reload |=> $stable(count_q))
		else $error("count moved while halted");
	a_run_increments: assert property (
		running && !wr_count && !do_reload |=> count_q == $past(count_q) + 16'h0001)
		else $error("running count did not increment");
	a_trig_sets_flag: assert property (
		ctrl_q.ext_trigger_enable && $fell(i_ext_trigger_pin) |=> o_ext_flag)
		else $error("trigger edge did not set external flag");
	a_no_trig_disabled: assert property (
		!ctrl_q.ext_trigger_enable && !(running && at_max) && !wr_count && !running
		|=> $stable(count_q))
		else $error("disabled trigger changed count");
	a_capture_copies: assert property (
		cap_evt |=> hold_q == $past(count_q))
		else $error("capture did not copy count");
	a_capture_mode_edge: assert property (
		ctrl_q.ext_trigger_enable && ctrl_q.capture_reload_select && trig_fall
		|=> hold_q == $past(count_q))
		else $error("edge in capture mode did not capture");
	a_reload_value: assert property (
		rld_trig && !wr_count |=> count_q == $past(hold_q))
		else $error("reload did not load holding value");
	a_overflow_flag: assert property (
		running && at_max && !baud_mode |=> o_overflow_flag ##0
		(count_q == ($past(auto_rld) ? $past(hold_q) : 16'h0000) || $past(wr_count)))
		else $error("rollover mishandled");

	// ==========================================================
	// Wrap, capture, holding and count write checks
	a_auto_reload_wrap: assert property (
		rollover && !ctrl_q.capture_reload_select && !wr_count
		|=> count_q == $past(hold_q))
		else $error("auto-reload rollover did not load holding value");
	a_capture_wraps_zero: assert property (
		rollover && ctrl_q.capture_reload_select && !baud_mode && !wr_count
		|=> count_q == 16'h0000)
		else $error("capture-mode rollover did not wrap to zero");
	a_capture_keeps_count: assert property (
		cap_evt && !running && !wr_count |=> $stable(count_q))
		else $error("capture disturbed a halted count");
	a_hold_steady: assert property (
		!cap_evt && !wr_hold_lo && !wr_hold_hi |=> $stable(hold_q))
		else $error("holding value changed without capture or write");
	a_soft_write_lands: assert property (
		wr_cnt_lo |=> count_q[7:0] == $past(i_sfr.wdata))
		else $error("count low byte write was lost");

	// ==========================================================
	// Flag checks
	a_halt_no_overflow: assert property (
		!running && !wr_ctrl |=> $stable(o_overflow_flag))
		else $error("overflow flag moved while halted");
	// Flags only fall through a software write to the control register
	a_overflow_sticky: assert property (
		o_overflow_flag && !wr_ctrl |=> o_overflow_flag)
		else $error("overflow flag dropped without a write");
	a_ext_flag_sticky: assert property (
		o_ext_flag && !wr_ctrl |=> o_ext_flag)
		else $error("external flag dropped without a write");

	c_overflow: cover property (ovf_set && auto_rld);
	c_capture: cover property (cap_evt);
	c_trig_reload: cover property (rld_trig && running);
	c_capture_wrap: cover property (rollover && ctrl_q.capture_reload_select);
	c_count_write: cover property (wr_count && !running);

endmodule : timer2_capture_reload

// ### dv/tb.sv
// Self-checking bench for the capture/reload timer.
// Assumes the design package and timer module are compiled first.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals and model state
	logic                 i_sys_clk         = 1'b0;
	logic                 i_arst_n          = 1'b0;
	timer2_pkg::sfr_req_s i_sfr             = '0;
	logic                 i_ext_trigger_pin = 1'b1;
	logic [7:0]           o_sfr_rdata;
	logic                 o_overflow_flag;
	logic                 o_ext_flag;
	int                   err_total = 0;
	int                   tests_run = 0;
	int                   cyc       = 0;
	logic [15:0]          lfsr      = 16'h0005;
	logic [15:0]          cnt;
	logic [15:0]          hld;
	logic [7:0]           m;
	logic [7:0]           modes [4] = '{8'h01, 8'h09, 8'h08, 8'h00};
	logic [7:0]           rmodes [3] = '{8'h00, 8'h01, 8'h13};

	timer2_capture_reload dut (.i_sys_clk, .i_arst_n, .i_sfr, .o_sfr_rdata,
		.i_ext_trigger_pin, .o_overflow_flag, .o_ext_flag);

	initial forever #2 i_sys_clk = ~i_sys_clk;

	// Generous ceiling: the sequence needs well under 400 cycles
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd

	task automatic acc(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d);
		i_sfr <= '{addr: a, wr: w, rd: r, wdata: d};
		@(posedge i_sys_clk);
	endtask : acc

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(a, 1'b1, 1'b0, d);
	endtask : wr

	// Read data stands until the next read, so it is checked one idle cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(a, 1'b0, 1'b1, 8'h00);
		acc(8'h00, 1'b0, 1'b0, 8'h00);
		chk(o_sfr_rdata, exp);
	endtask : rd

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask : wr16

	task automatic rd16(input logic [7:0] a, input logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 8'h01, v[15:8]);
	endtask : rd16

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Sequence
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		@(posedge i_sys_clk);
		for (int a = 8'hC8; a <= 8'hCD; a++) rd(8'(a), 8'h00);
		$display("reset values done");
		cnt = rnd() & 16'h7FFF;
		wr16(timer2_pkg::ADDR_COUNT_LO, cnt);
		repeat (5) acc(8'h00, 1'b0, 1'b0, 8'h00);
		rd16(timer2_pkg::ADDR_COUNT_LO, cnt);
		wr(timer2_pkg::ADDR_CTRL, 8'h04);
		repeat (9) acc(8'h00, 1'b0, 1'b0, 8'h00);
		wr(timer2_pkg::ADDR_CTRL, 8'h00);
		cnt = cnt + 16'h000A;
		rd16(timer2_pkg::ADDR_COUNT_LO, cnt);
		$display("run and halt done");
		foreach (rmodes[k]) begin
			m = rmodes[k];
			hld = rnd();
			wr16(timer2_pkg::ADDR_HOLD_LO, hld);
			wr16(timer2_pkg::ADDR_COUNT_LO, 16'hFFFF);
			wr(timer2_pkg::ADDR_CTRL, 8'h04 | m);
			wr(timer2_pkg::ADDR_CTRL, m);
			// Baud selections force reload and keep the overflow flag low
			cnt = (m[0] && !m[4] && !m[5]) ? 16'h0000 : hld;
			rd16(timer2_pkg::ADDR_COUNT_LO, cnt);
			rd(timer2_pkg::ADDR_CTRL, (m[4] || m[5]) ? m : (8'h80 | m));
			chk({7'h00, o_overflow_flag}, {7'h00, !(m[4] || m[5])});
			wr(timer2_pkg::ADDR_CTRL, 8'h00);
		end
		$display("rollover done");
		foreach (modes[i]) begin
			m = modes[i];
			cnt = rnd();
			hld = rnd();
			wr16(timer2_pkg::ADDR_COUNT_LO, cnt);
			wr16(timer2_pkg::ADDR_HOLD_LO, hld);
			wr(timer2_pkg::ADDR_CTRL, m);
			i_ext_trigger_pin <= 1'b0;
			repeat (3) acc(8'h00, 1'b0, 1'b0, 8'h00);
			if (m[3] && m[0]) hld = cnt;
			else if (m[3]) cnt = hld;
			chk({7'h00, o_ext_flag}, {7'h00, m[3]});
			rd16(timer2_pkg::ADDR_HOLD_LO, hld);
			rd16(timer2_pkg::ADDR_COUNT_LO, cnt);
			i_ext_trigger_pin <= 1'b1;
			wr(timer2_pkg::ADDR_CTRL, 8'h00);
		end
		$display("trigger modes done");
		hld = rnd();
		wr16(timer2_pkg::ADDR_HOLD_LO, hld);
		wr16(timer2_pkg::ADDR_COUNT_LO, 16'h0000);
		wr(timer2_pkg::ADDR_CTRL, 8'h0C);
		i_ext_trigger_pin <= 1'b0;
		wr(timer2_pkg::ADDR_CTRL, 8'h08);
		rd16(timer2_pkg::ADDR_COUNT_LO, hld);
		rd(timer2_pkg::ADDR_CTRL, 8'h48);
		i_ext_trigger_pin <= 1'b1;
		wr(timer2_pkg::ADDR_CTRL, 8'h00);
		$display("running reload done");
		tally_and_finish();
	end
endmodule : tb
